// [serial_tx_pkg.sv]
// Package of register map, field layouts and constants for the serial transmitter
package serial_tx_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_TX_LOWER = 12'h000;
  localparam logic [11:0] ADDR_TX_UPPER = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_ENABLE = 12'h00c;
  localparam logic [11:0] ADDR_FORMAT = 12'h010;
  localparam logic [11:0] ADDR_DIVISOR = 12'h014;
  localparam logic [11:0] ADDR_MODE = 12'h018;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Status: bit0 complete flag (write 1 clears), bit1 buffer empty,
  // bit2 transmitter active
  localparam int ST_COMPLETE = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_ACTIVE = 2;
  // Enable register
  localparam int EN_TX = 0;
  localparam int EN_RX = 1;
  localparam int EN_OPEN_DRAIN = 2;
  localparam int EN_DOUBLE_SPEED = 3;
  // Mode register
  localparam int MD_LOOPBACK = 0;
  localparam int MD_SYNC = 1;
  localparam int MD_EXT_CLOCK = 2;
  localparam int MD_LINE_DRIVER = 3;
  // Format register: [2:0] size, [5:4] parity, [6] two stops
  localparam int FM_SIZE_LSB = 0;
  localparam int FM_PAR_LSB = 4;
  localparam int FM_TWO_STOP = 6;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SIZE_5 = 3'h0;
  localparam logic [2:0] SIZE_9 = 3'h4;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam logic [15:0] DIVISOR_RESET = 16'h0040;
  localparam logic [7:0] FORMAT_RESET = 8'h03;
  localparam int FRAC_BITS = 6;
  localparam int SAMPLES_NORMAL = 16;
  localparam int SAMPLES_DOUBLE = 8;
  localparam int SAMPLES_SYNC = 2;
  localparam logic [4:0] MIN_DATA_BITS = 5'h05;

  typedef enum {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_PARITY,
    TX_STOP
  } tx_state_t;

endpackage

// [frac_baud_gen.sv]
// Fractional bit-rate generator producing one tick per bit period
`timescale 1ns/10ps
module frac_baud_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [15:0] divisor,
  input wire logic [4:0] samples,
  input wire logic sync_mode,
  output logic bit_tick
);
  // Accumulator in 1/64 clock units; each clock adds 64, i.e.
  // tick when accumulated clocks*64 reach samples*divisor.
  logic [22:0] acc_q;
  logic [22:0] target;
  logic [22:0] step;

  // Target per bit: samples * divisor, integer part only when synchronous
  always_comb
  begin
    if (sync_mode)
      target = 23'({divisor[15:serial_tx_pkg::FRAC_BITS], 6'h00})
        * 23'(samples);
    else
      target = 23'(divisor) * 23'(samples);
    step = 23'(1) << serial_tx_pkg::FRAC_BITS;
  end

  // Remainder carried over so fraction stretches some bits by a cycle
  always_ff @(posedge clk)
  begin
    if (rst || !run)
      acc_q <= 23'h000000;
    else if (acc_q + step >= target)
      acc_q <= acc_q + step - target;
    else
      acc_q <= acc_q + step;
  end

  assign bit_tick = run && (acc_q + step >= target);
endmodule // frac_baud_gen

// [pin_sync.sv]
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  logic sync_q;

  // Meta stage read only by the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule // pin_sync

// [serial_tx.sv]
// Serial transmitter with fractional bit-rate generator and APB registers
//
// Behaviour
// - Frame: start bit, five to nine data bits, optional parity, one/two stops.
// - Parity bit follows last data bit, before first stop bit.
// - Start bit low, stop bits high, idle line high.
// - Next frame follows stop bit directly if data pending, else idle.
// - Divisor low six bits are a fraction that stretches bit timing.
// - Async rate is 64 times clock over samples times divisor.
// - Synchronous mode uses only divisor integer part, two samples per bit.
// - Writing buffer starts sending; word moves to shifter when it empties.
// - Complete flag sets when frame done and buffer empty.
// - Surplus upper data bits ignored for characters under eight bits.
// - Disable takes effect only once shifter and buffer are drained.
// - Disabled transmitter releases pin override and makes pin input.
// - Open-drain mode drives transmit pin only while low; pin is input when high.
// - Loopback routes transmit line internally to the receiver input.
// - One buffered word plus shifter.
// - Direction output serves as RS-485 line driver transmit enable.
// - Shift clock from fractional generator or from transfer clock pin.
`timescale 1ns/10ps
module serial_tx #(
  parameter int DATA_MAX = 9
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TX_PIN_IN,
  output logic TX_PIN_OUT,
  output logic TX_PIN_OE,
  input wire logic RX_PIN_IN,
  input wire logic TRANSFER_CLOCK_PIN,
  output logic LINE_DRIVER_ENABLE,
  output logic RX_LINE,
  output logic PORT_OVERRIDE,
  output logic TX_COMPLETE_FLAG,
  output logic TX_BUFFER_EMPTY_FLAG
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] divisor_q;
  logic [7:0] format_q;
  logic [3:0] enable_q;
  logic [3:0] mode_q;
  logic [8:0] hold_q;
  logic upper_q;
  logic full_q;
  logic complete_q;
  logic tx_active_q;
  serial_tx_pkg::tx_state_t state_q;
  logic [8:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic stop_cnt_q;
  logic parity_q;
  logic line_q;
  logic xck_prev_q;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic load_shift;
  logic frame_end;
  logic tick;
  logic gen_tick;
  logic xck_s;
  logic rx_s;
  logic tx_in_s;
  logic [4:0] samples;
  logic [3:0] data_bits;
  logic [8:0] masked;

  // Data bits for the configured character size
  function automatic logic [3:0] size_bits(input logic [2:0] sz);
    if (sz > serial_tx_pkg::SIZE_9)
      return 4'(serial_tx_pkg::MIN_DATA_BITS);
    return 4'(sz) + 4'(serial_tx_pkg::MIN_DATA_BITS);
  endfunction

  // Keep only the configured number of data bits
  function automatic logic [8:0] mask_data(input logic [8:0] d,
                                           input logic [3:0] n);
    logic [8:0] m;
    m = 9'h1ff >> (4'(DATA_MAX) - n);
    return d & m;
  endfunction

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign rd_acc = PSEL && !PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  always_comb
  begin
    case (PADDR)
      serial_tx_pkg::ADDR_TX_LOWER,
      serial_tx_pkg::ADDR_TX_UPPER,
      serial_tx_pkg::ADDR_STATUS,
      serial_tx_pkg::ADDR_ENABLE,
      serial_tx_pkg::ADDR_FORMAT,
      serial_tx_pkg::ADDR_DIVISOR,
      serial_tx_pkg::ADDR_MODE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // Read data registered in the setup phase, stable through the access
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      PRDATA <= 32'h00000000;
    else if (rd_acc)
    begin
      case (PADDR)
        serial_tx_pkg::ADDR_TX_UPPER: PRDATA <= {31'h0, upper_q};
        serial_tx_pkg::ADDR_STATUS:
          PRDATA <= {29'h0, tx_active_q, !full_q, complete_q};
        serial_tx_pkg::ADDR_ENABLE: PRDATA <= {28'h0, enable_q};
        serial_tx_pkg::ADDR_FORMAT: PRDATA <= {24'h0, format_q};
        serial_tx_pkg::ADDR_DIVISOR: PRDATA <= {16'h0, divisor_q};
        serial_tx_pkg::ADDR_MODE: PRDATA <= {28'h0, mode_q};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      divisor_q <= serial_tx_pkg::DIVISOR_RESET;
      format_q <= serial_tx_pkg::FORMAT_RESET;
      enable_q <= 4'h0;
      mode_q <= 4'h0;
    end
    else if (wr_acc)
    begin
      case (PADDR)
        serial_tx_pkg::ADDR_DIVISOR: divisor_q <= PWDATA[15:0];
        serial_tx_pkg::ADDR_FORMAT: format_q <= PWDATA[7:0];
        serial_tx_pkg::ADDR_ENABLE: enable_q <= PWDATA[3:0];
        serial_tx_pkg::ADDR_MODE: mode_q <= PWDATA[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer and flags
  // ----------------------------------------------------------------
  assign data_bits = size_bits(format_q[serial_tx_pkg::FM_SIZE_LSB +: 3]);
  assign masked = mask_data({upper_q, PWDATA[7:0]}, data_bits);

  // Upper ninth bit staged before the lower byte write
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      upper_q <= 1'b0;
    else if (wr_acc && PADDR == serial_tx_pkg::ADDR_TX_UPPER)
      upper_q <= PWDATA[0];
  end

  // One holding word beside the shifter; write arms it
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      hold_q <= 9'h000;
      full_q <= 1'b0;
    end
    else if (wr_acc && PADDR == serial_tx_pkg::ADDR_TX_LOWER
             && enable_q[serial_tx_pkg::EN_TX])
    begin
      hold_q <= masked;
      full_q <= 1'b1;
    end
    else if (load_shift)
      full_q <= 1'b0;
  end

  // Complete flag: set beats a same-cycle write-one clear
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      complete_q <= 1'b0;
    else if (frame_end && !full_q)
      complete_q <= 1'b1;
    else if (wr_acc && PADDR == serial_tx_pkg::ADDR_STATUS
             && PWDATA[serial_tx_pkg::ST_COMPLETE])
      complete_q <= 1'b0;
    else if (load_shift)
      complete_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  always_comb
  begin
    if (mode_q[serial_tx_pkg::MD_SYNC])
      samples = 5'(serial_tx_pkg::SAMPLES_SYNC);
    else if (enable_q[serial_tx_pkg::EN_DOUBLE_SPEED])
      samples = 5'(serial_tx_pkg::SAMPLES_DOUBLE);
    else
      samples = 5'(serial_tx_pkg::SAMPLES_NORMAL);
  end

  frac_baud_gen u_gen (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .run(tx_active_q && state_q != serial_tx_pkg::TX_IDLE),
    .divisor(divisor_q),
    .samples(samples),
    .sync_mode(mode_q[serial_tx_pkg::MD_SYNC]),
    .bit_tick(gen_tick)
  );

  pin_sync u_xck (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .din(TRANSFER_CLOCK_PIN),
    .dout(xck_s)
  );

  pin_sync u_rx (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .din(RX_PIN_IN),
    .dout(rx_s)
  );

  pin_sync u_txin (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .din(TX_PIN_IN),
    .dout(tx_in_s)
  );

  // Edge history of the synchronised transfer clock
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      xck_prev_q <= 1'b1; // Matches synchroniser reset, no false edge
    else
      xck_prev_q <= xck_s;
  end

  // Rising external clock edge starts a bit when clocked externally
  assign tick = mode_q[serial_tx_pkg::MD_EXT_CLOCK]
    ? (xck_s && !xck_prev_q && state_q != serial_tx_pkg::TX_IDLE)
    : gen_tick;

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  assign frame_end = tick && state_q == serial_tx_pkg::TX_STOP
    && (stop_cnt_q || !format_q[serial_tx_pkg::FM_TWO_STOP]);
  assign load_shift = full_q && tx_active_q
    && (state_q == serial_tx_pkg::TX_IDLE || frame_end);

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      state_q <= serial_tx_pkg::TX_IDLE;
      shift_q <= 9'h000;
      bit_cnt_q <= 4'h0;
      stop_cnt_q <= 1'b0;
      parity_q <= 1'b0;
      line_q <= 1'b1;
    end
    else if (load_shift)
    begin
      state_q <= serial_tx_pkg::TX_START;
      shift_q <= hold_q;
      bit_cnt_q <= 4'h0;
      stop_cnt_q <= 1'b0;
      parity_q <= format_q[serial_tx_pkg::FM_PAR_LSB +: 2]
        == serial_tx_pkg::PAR_ODD;
      line_q <= 1'b0;
    end
    else if (tick)
    begin
      case (state_q)
        serial_tx_pkg::TX_START:
        begin
          state_q <= serial_tx_pkg::TX_DATA;
          line_q <= shift_q[0];
          parity_q <= parity_q ^ shift_q[0];
          shift_q <= shift_q >> 1;
          bit_cnt_q <= 4'h1;
        end
        serial_tx_pkg::TX_DATA:
        begin
          if (bit_cnt_q != data_bits)
          begin
            line_q <= shift_q[0];
            parity_q <= parity_q ^ shift_q[0];
            shift_q <= shift_q >> 1;
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (format_q[serial_tx_pkg::FM_PAR_LSB +: 2]
                   == serial_tx_pkg::PAR_EVEN
                   || format_q[serial_tx_pkg::FM_PAR_LSB +: 2]
                   == serial_tx_pkg::PAR_ODD)
          begin
            state_q <= serial_tx_pkg::TX_PARITY;
            line_q <= parity_q;
          end
          else
          begin
            state_q <= serial_tx_pkg::TX_STOP;
            line_q <= 1'b1;
          end
        end
        serial_tx_pkg::TX_PARITY:
        begin
          state_q <= serial_tx_pkg::TX_STOP;
          line_q <= 1'b1;
        end
        serial_tx_pkg::TX_STOP:
        begin
          if (!frame_end)
            stop_cnt_q <= 1'b1;
          else
          begin
            state_q <= serial_tx_pkg::TX_IDLE;
            line_q <= 1'b1;
          end
        end
        default:
        begin
          state_q <= serial_tx_pkg::TX_IDLE;
          line_q <= 1'b1;
        end
      endcase
    end
  end

  // Transmitter stays active until drained after a disable request
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      tx_active_q <= 1'b0;
    else if (enable_q[serial_tx_pkg::EN_TX])
      tx_active_q <= 1'b1;
    else if (!full_q && state_q == serial_tx_pkg::TX_IDLE)
      tx_active_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Pin control
  // ----------------------------------------------------------------
  // Open drain drives low only; push-pull drives both levels
  always_comb
  begin
    PORT_OVERRIDE = tx_active_q;
    if (!tx_active_q)
    begin
      TX_PIN_OUT = 1'b0;
      TX_PIN_OE = 1'b0;
    end
    else if (enable_q[serial_tx_pkg::EN_OPEN_DRAIN])
    begin
      TX_PIN_OUT = 1'b0;
      TX_PIN_OE = !line_q;
    end
    else
    begin
      TX_PIN_OUT = line_q;
      TX_PIN_OE = 1'b1;
    end
  end

  // Loopback feeds the transmit line to the receiver input
  assign RX_LINE = mode_q[serial_tx_pkg::MD_LOOPBACK]
    ? (line_q & tx_in_s) : rx_s;
  assign LINE_DRIVER_ENABLE = mode_q[serial_tx_pkg::MD_LINE_DRIVER]
    && state_q != serial_tx_pkg::TX_IDLE;
  assign TX_COMPLETE_FLAG = complete_q;
  assign TX_BUFFER_EMPTY_FLAG = !full_q;

endmodule // serial_tx

// [serial_tx_properties.sv]
// Checker of the serial transmitter port behaviour
`timescale 1ns/10ps
module serial_tx_properties (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic TX_PIN_OUT,
  input wire logic TX_PIN_OE,
  input wire logic LINE_DRIVER_ENABLE,
  input wire logic RX_LINE,
  input wire logic PORT_OVERRIDE,
  input wire logic TX_COMPLETE_FLAG,
  input wire logic TX_BUFFER_EMPTY_FLAG
);
  logic wr;
  logic [3:0] mode_q;
  logic [3:0] en_q;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  // ------------
  // Mirrors
  // ------------
  // Copies of the mode and enable bits taken from bus writes
  assign wr = PSEL && PENABLE && PWRITE;
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      mode_q <= 4'h0;
      en_q <= 4'h0;
    end
    else if (wr && PADDR == serial_tx_pkg::ADDR_MODE)
    begin
      mode_q <= PWDATA[3:0];
    end
    else if (wr && PADDR == serial_tx_pkg::ADDR_ENABLE)
    begin
      en_q <= PWDATA[3:0];
    end
  end

  // ------------
  // Assertions
  // ------------
  idle_line_high_a: assert property (
    TX_COMPLETE_FLAG && TX_BUFFER_EMPTY_FLAG && TX_PIN_OE |-> TX_PIN_OUT)
    else $error("line not idle high");
  complete_when_drained_a: assert property (
    $rose(TX_COMPLETE_FLAG)
    |-> TX_BUFFER_EMPTY_FLAG && (TX_PIN_OUT || !TX_PIN_OE))
    else $error("complete with data pending");
  buffer_moves_on_a: assert property (
    $fell(TX_BUFFER_EMPTY_FLAG) |-> ##[1:600] TX_BUFFER_EMPTY_FLAG)
    else $error("buffer word never moved");
  hold_while_pending_a: assert property (
    !TX_BUFFER_EMPTY_FLAG |-> PORT_OVERRIDE)
    else $error("pin released with word pending");
  pin_released_input_a: assert property (
    !PORT_OVERRIDE |-> !TX_PIN_OE)
    else $error("pin driven after release");
  open_drain_output_a: assert property (
    en_q[serial_tx_pkg::EN_OPEN_DRAIN] && PORT_OVERRIDE |-> !TX_PIN_OUT)
    else $error("open drain pin driven high");
  loopback_route_a: assert property (
    mode_q[serial_tx_pkg::MD_LOOPBACK] && TX_PIN_OE && !TX_PIN_OUT
    |-> ##[0:3] !RX_LINE)
    else $error("loopback low not seen");
  driver_enable_a: assert property (
    mode_q[serial_tx_pkg::MD_LINE_DRIVER] && TX_PIN_OE && !TX_PIN_OUT
    |-> LINE_DRIVER_ENABLE)
    else $error("line driver off in frame");
  status_readback_a: assert property (
    PSEL && PENABLE && !PWRITE && PADDR == serial_tx_pkg::ADDR_STATUS
    |-> PRDATA[1:0] == {$past(TX_BUFFER_EMPTY_FLAG), $past(TX_COMPLETE_FLAG)})
    else $error("status read mismatch");
endmodule // serial_tx_properties

bind serial_tx serial_tx_properties chk (.REF_CLK, .SYS_RST, .PSEL,
  .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .TX_PIN_OUT, .TX_PIN_OE,
  .LINE_DRIVER_ENABLE, .RX_LINE, .PORT_OVERRIDE, .TX_COMPLETE_FLAG,
  .TX_BUFFER_EMPTY_FLAG);

// [serial_partner.sv]
// Remote serial partner that decodes frames on the transmit wire
`timescale 1ns/10ps
module serial_partner (
  input wire logic clk,
  input wire logic line,
  input wire logic [15:0] bit_x64,
  input wire logic [3:0] nbits,
  input wire logic ext_clk,
  output logic rx_pin,
  output logic xck_pin
);
  logic [12:0] frame_q[$];
  int start_q[$];
  int cyc;
  int el;
  int tgt;
  int hc;
  logic [12:0] f;

  // Receive line idles high
  initial
  begin
    rx_pin = 1'b1;
    cyc = 0;
  end

  // Transfer clock of one bit period while enabled, else held low
  always @(negedge clk)
  begin
    if (!ext_clk || hc + 1 >= int'(bit_x64) / 128)
    begin
      hc <= 0;
      xck_pin <= ext_clk && !xck_pin;
    end
    else
      hc <= hc + 1;
  end

  // Cycle count on the falling edge, clear of wire updates
  always @(negedge clk)
  begin
    cyc <= cyc + 1;
  end

  // Mid-bit sampler; records start cycle and bits of each frame
  always
  begin
    @(negedge line);
    start_q.push_back(cyc);
    f = '1;
    el = 0;
    for (int i = 0; i < int'(nbits); i++)
    begin
      tgt = (int'(bit_x64) * (2 * i + 1)) / 128;
      repeat (tgt - el) @(negedge clk);
      el = tgt;
      f[i] = line;
    end
    frame_q.push_back(f);
  end
endmodule // serial_partner

// [serial_tx_test.sv]
// Testbench of the serial transmitter against a remote partner
`timescale 1ns/10ps
module serial_tx_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pin_out, pin_oe, rx_pin, transfer_clock_pin, ldrv, rx_line;
  logic ovr, txc, dre, err, two;
  logic xon = 1'b0;
  logic [31:0] rd;
  logic [15:0] bit_x64 = 16'h0400;
  logic [3:0] nbits = 4'ha;
  logic [8:0] d;
  logic [1:0] par;
  logic [1:0] pars [3] = '{2'h0, 2'h2, 2'h3};
  int error_cnt = 0;
  int n_compared = 0;
  int n, t, c;
  wire logic wire_lvl;

  // Pulled-up wire seen by both ends
  assign wire_lvl = pin_oe ? pin_out : 1'b1;

  // Clock
  always #2 clk = ~clk;

  serial_tx dut (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TX_PIN_IN(wire_lvl), .TX_PIN_OUT(pin_out), .TX_PIN_OE(pin_oe),
    .RX_PIN_IN(rx_pin), .TRANSFER_CLOCK_PIN(transfer_clock_pin),
    .LINE_DRIVER_ENABLE(ldrv), .RX_LINE(rx_line), .PORT_OVERRIDE(ovr),
    .TX_COMPLETE_FLAG(txc), .TX_BUFFER_EMPTY_FLAG(dre));
  serial_partner partner (.clk(clk), .line(wire_lvl), .bit_x64(bit_x64),
    .nbits(nbits), .ext_clk(xon), .rx_pin(rx_pin), .xck_pin(transfer_clock_pin));

  // ------------
  // Tasks
  // ------------
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] v);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_near(input int got, input int exp);
    n_compared++;
    if (got < exp - 1 || got > exp + 1)
    begin
      error_cnt++;
      $display("[ERR] %0t span %0d exp %0d", $time, got, exp);
    end
  endtask

  task automatic setup(input logic [15:0] dv, input logic [7:0] fm,
                       input logic [3:0] md, input logic [3:0] en);
    apb(serial_tx_pkg::ADDR_DIVISOR, 1'b1, {16'h0, dv});
    apb(serial_tx_pkg::ADDR_FORMAT, 1'b1, {24'h0, fm});
    apb(serial_tx_pkg::ADDR_MODE, 1'b1, {28'h0, md});
    apb(serial_tx_pkg::ADDR_ENABLE, 1'b1, {28'h0, en});
  endtask

  task automatic send(input logic [8:0] v);
    for (t = 0; t < 4000 && dre !== 1'b1; t++) @(negedge clk);
    @(posedge clk);
    apb(serial_tx_pkg::ADDR_TX_UPPER, 1'b1, {31'h0, v[8]});
    apb(serial_tx_pkg::ADDR_TX_LOWER, 1'b1, {24'h0, v[7:0]});
  endtask

  task automatic wait_done;
    for (t = 0; t < 4000 && !(txc === 1'b1 && dre === 1'b1); t++)
      @(negedge clk);
    @(posedge clk);
    check({31'h0, txc}, 32'h1);
  endtask

  function automatic logic [31:0] frame(input logic [8:0] v, input int nb,
                                        input logic [1:0] pa);
    logic [12:0] f;
    logic p;
    f = '1;
    f[0] = 1'b0;
    p = (pa == serial_tx_pkg::PAR_ODD);
    for (int i = 0; i < nb; i++)
    begin
      f[i + 1] = v[i];
      p ^= v[i];
    end
    if (pa != serial_tx_pkg::PAR_NONE)
      f[nb + 1] = p;
    return 32'(f);
  endfunction

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ------------
  // Tests
  // ------------
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(serial_tx_pkg::ADDR_STATUS, 1'b0, 32'h0);
    check(rd, 32'h2);
    apb(serial_tx_pkg::ADDR_DIVISOR, 1'b0, 32'h0);
    check(rd, {16'h0, serial_tx_pkg::DIVISOR_RESET});
    apb(12'h0fc, 1'b0, 32'h0);
    check({30'h0, err, rx_line}, 32'h3);
    apb(serial_tx_pkg::ADDR_TX_LOWER, 1'b1, 32'h5);
    check({31'h0, dre}, 32'h1);
    for (int k = 0; k < 30; k++)
    begin
      n = 5 + k % 5;
      par = pars[(k / 5) % 3];
      two = (k >= 15);
      d = 9'h1a5 ^ 9'(k * 37);
      nbits <= 4'(2 + n + (par != 2'h0) + two);
      setup(16'h0040, {1'b0, two, par, 1'b0, 3'(n - 5)}, 4'h0, 4'h3);
      send(d);
      wait_done();
      check(32'(partner.frame_q.pop_front()), frame(d, n, par));
    end
    apb(serial_tx_pkg::ADDR_STATUS, 1'b1, 32'h1);
    check({31'h0, txc}, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      bit_x64 <= (m == 0) ? 16'd1152 : (m == 1) ? 16'd544
        : (m == 2) ? 16'd256 : 16'd1024;
      nbits <= (m == 3) ? 4'h9 : 4'ha;
      xon <= (m == 3);
      setup((m == 0) ? 16'h0048 : (m == 1) ? 16'h0044 : 16'h0080, 8'h03,
            (m == 2) ? 4'h2 : (m == 3) ? 4'h4 : 4'h0,
            (m == 1) ? 4'h9 : 4'h1);
      send(9'h055);
      send(9'h0aa);
      send(9'h0aa);
      wait_done();
      check_near(partner.start_q[$] - partner.start_q[$ - 1],
                 10 * int'(bit_x64) / 64);
      check(32'(partner.frame_q[$]), frame(9'h0aa, 8, 2'h0));
    end
    bit_x64 <= 16'd1024;
    xon <= 1'b0;
    setup(16'h0040, 8'h03, 4'h0, 4'h1);
    c = partner.frame_q.size();
    send(9'h011);
    send(9'h022);
    apb(serial_tx_pkg::ADDR_ENABLE, 1'b1, 32'h0);
    check({31'h0, ovr}, 32'h1);
    wait_done();
    for (t = 0; t < 8 && ovr !== 1'b0; t++) @(negedge clk);
    @(posedge clk);
    check(32'(partner.frame_q.size() - c), 32'h2);
    check({30'h0, ovr, pin_oe}, 32'h0);
    apb(serial_tx_pkg::ADDR_TX_LOWER, 1'b1, 32'h33);
    check({31'h0, dre}, 32'h1);
    setup(16'h0040, 8'h03, 4'h9, 4'h7);
    send(9'h0c3);
    for (t = 0; t < 100 && wire_lvl !== 1'b0; t++) @(negedge clk);
    repeat (3) @(negedge clk);
    check({29'h0, pin_oe, ldrv, rx_line}, 32'h6);
    @(posedge clk);
    wait_done();
    check(32'(partner.frame_q[$]), frame(9'h0c3, 8, 2'h0));
    finish_test();
  end

  // Watchdog
  initial
  begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule // serial_tx_test
